// file: hdl/ctu_defines.vh
// constants for the charge time edge control block
//
// Operation
// - unit_enable, control-high bit 7, turns the unit on or off; source_ground still acts while it is off.
// - stop_in_idle, bit 5, halts the unit while the device is idle.
// - delay_generation_enable, bit 4, switches edge-delay generation on or off.
// - edge_gate_enable, bit 3, passes edges when set, blocks all when clear.
// - edge_order_enable, bit 2, accepts edge two only after edge one.
// - source_ground, bit 1, ties the current source output to ground.
// - adc_trigger_enable, bit 0, allows or suppresses the converter trigger output.
// - control-high bit 6 is unimplemented and reads as zero.
// - each channel picks one of four level-sensitive sources: two pins, two compare triggers.
// - each channel has its own polarity select besides its source select.
// - the unit can issue a special event that starts a conversion.
// - in delay mode the charging node goes to a comparator that ends the delay.
// - edge flags (bit 0, bit 1) set on a detected response; software may set them.
// - current source is on only while exactly one edge flag is set.
// - interrupt flag sets when the source goes from on to off; enable gates it.
// - select 11 pin a, 10 pin b, 01 compare one, 00 compare two; polarity 1 positive.
`ifndef CTU_DEFINES_VH
`define CTU_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CTU_OFS_CTRL_HIGH   12'h000
`define CTU_OFS_CTRL_LOW    12'h004
`define CTU_OFS_IRQ_STATUS  12'h008
`define CTU_OFS_IRQ_CLEAR   12'h00C
`define CTU_OFS_IRQ_ENABLE  12'h010

// ----------------------------------------------------------------
// control-high fields
// ----------------------------------------------------------------
`define CTU_HI_UNIT_EN      7
`define CTU_HI_STOP_IDLE    5
`define CTU_HI_DELAY_GEN    4
`define CTU_HI_EDGE_GATE    3
`define CTU_HI_EDGE_ORDER   2
`define CTU_HI_SRC_GROUND   1
`define CTU_HI_ADC_TRIG     0
`define CTU_HI_IMPL_MASK    8'hBF
`define CTU_HI_RESET        8'h00

// ----------------------------------------------------------------
// control-low fields
// ----------------------------------------------------------------
`define CTU_LO_TWO_POL      7
`define CTU_LO_TWO_SEL_HI   6
`define CTU_LO_TWO_SEL_LO   5
`define CTU_LO_ONE_POL      4
`define CTU_LO_ONE_SEL_HI   3
`define CTU_LO_ONE_SEL_LO   2
`define CTU_LO_TWO_FLAG     1
`define CTU_LO_ONE_FLAG     0
`define CTU_LO_RESET        8'h00

// ----------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------
`define CTU_SEL_PIN_A       2'h3
`define CTU_SEL_PIN_B       2'h2
`define CTU_SEL_CMP_ONE     2'h1
`define CTU_SEL_CMP_TWO     2'h0

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define CTU_IRQ_SRC_OFF     0
`define CTU_IRQ_DELAY_END   1
`define CTU_IRQ_WIDTH       2
`define CTU_IRQ_RESET       2'h0

`endif

// file: hdl/ctu_edge_ctrl.v
// charge time unit digital control: edge channels, flags, current gate, apb registers
`timescale 1ns/100ps
`default_nettype none
`include "ctu_defines.vh"

module ctu_edge_ctrl #(
    parameter ADDR_WIDTH = 12
) (
    // clock and reset
    input  wire                  core_clk,
    input  wire                  srst,
    // apb slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [ADDR_WIDTH-1:0] paddr,
    input  wire [31:0]           pwdata,
    output wire                  pready,
    output wire                  pslverr,
    output reg  [31:0]           prdata,
    // edge sources
    input  wire                  edgePinA,
    input  wire                  edgePinB,
    input  wire                  cmpOneTrig,
    input  wire                  cmpTwoTrig,
    // device state and analog side
    input  wire                  idleMode,
    input  wire                  delayCmpOut,
    output reg                   currentSourceOn,
    output reg                   sourceGround,
    output reg                   chargeToComparator,
    output reg                   adcTrigger,
    output reg                   delayDone,
    output reg                   irq
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [7:0]                ctrlHigh_reg;
    reg  [7:0]                ctrlLow_reg;
    reg  [`CTU_IRQ_WIDTH-1:0] irqStatus_reg;
    reg  [`CTU_IRQ_WIDTH-1:0] irqEnable_reg;
    reg  [2:0]                pinASync_reg;
    reg  [2:0]                pinBSync_reg;
    reg  [2:0]                cmpSync_reg;
    reg                       pinA_reg;
    reg                       pinB_reg;
    reg                       cmpLevel_reg;
    reg                       cmpPrev_reg;
    reg                       srcOnPrev_reg;

    reg  [7:0]                ctrlLow_next;
    reg  [`CTU_IRQ_WIDTH-1:0] irqStatus_next;
    reg  [31:0]               readData;
    reg                       addrHit;

    wire       apbWrite  = psel & penable & pwrite;
    wire       apbSetup  = psel & ~penable;

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    wire       unitEnable   = ctrlHigh_reg[`CTU_HI_UNIT_EN];
    wire       stopInIdle   = ctrlHigh_reg[`CTU_HI_STOP_IDLE];
    wire       delayGenEn   = ctrlHigh_reg[`CTU_HI_DELAY_GEN];
    wire       edgeGateEn   = ctrlHigh_reg[`CTU_HI_EDGE_GATE];
    wire       edgeOrderEn  = ctrlHigh_reg[`CTU_HI_EDGE_ORDER];
    wire       adcTrigEn    = ctrlHigh_reg[`CTU_HI_ADC_TRIG];
    wire       flagOne      = ctrlLow_reg[`CTU_LO_ONE_FLAG];
    wire       flagTwo      = ctrlLow_reg[`CTU_LO_TWO_FLAG];
    wire [1:0] oneSource    = ctrlLow_reg[`CTU_LO_ONE_SEL_HI:`CTU_LO_ONE_SEL_LO];
    wire [1:0] twoSource    = ctrlLow_reg[`CTU_LO_TWO_SEL_HI:`CTU_LO_TWO_SEL_LO];
    wire       onePolarity  = ctrlLow_reg[`CTU_LO_ONE_POL];
    wire       twoPolarity  = ctrlLow_reg[`CTU_LO_TWO_POL];

    // unit runs only when enabled and not parked by idle
    wire       unitRunning  = unitEnable & ~(stopInIdle & idleMode);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            pinASync_reg <= 3'h0;
            pinBSync_reg <= 3'h0;
            cmpSync_reg  <= 3'h0;
            pinA_reg     <= 1'b0;
            pinB_reg     <= 1'b0;
            cmpLevel_reg <= 1'b0;
        end else begin
            pinASync_reg <= {pinASync_reg[1:0], edgePinA};
            pinBSync_reg <= {pinBSync_reg[1:0], edgePinB};
            cmpSync_reg  <= {cmpSync_reg[1:0], delayCmpOut};
            if (pinASync_reg[1] == pinASync_reg[2]) begin
                pinA_reg <= pinASync_reg[2];
            end
            if (pinBSync_reg[1] == pinBSync_reg[2]) begin
                pinB_reg <= pinBSync_reg[2];
            end
            if (cmpSync_reg[1] == cmpSync_reg[2]) begin
                cmpLevel_reg <= cmpSync_reg[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // edge channels
    // ----------------------------------------------------------------
    function srcPick;
        input [1:0] sel;
        input       pinA;
        input       pinB;
        input       cmpOne;
        input       cmpTwo;
        begin
            case (sel)
                `CTU_SEL_PIN_A:   srcPick = pinA;
                `CTU_SEL_PIN_B:   srcPick = pinB;
                `CTU_SEL_CMP_ONE: srcPick = cmpOne;
                default:          srcPick = cmpTwo;
            endcase
        end
    endfunction

    // level-sensitive: a channel responds while its level matches the polarity
    wire oneLevel = srcPick(oneSource, pinA_reg, pinB_reg, cmpOneTrig, cmpTwoTrig);
    wire twoLevel = srcPick(twoSource, pinA_reg, pinB_reg, cmpOneTrig, cmpTwoTrig);
    wire oneHit   = ~(oneLevel ^ onePolarity);
    wire twoHit   = ~(twoLevel ^ twoPolarity);

    wire edgesPass = unitRunning & edgeGateEn;
    wire oneSet    = edgesPass & oneHit;
    wire twoSet    = edgesPass & twoHit & (~edgeOrderEn | flagOne);

    // ----------------------------------------------------------------
    // edge flags in control-low
    // ----------------------------------------------------------------
    always @* begin
        ctrlLow_next = ctrlLow_reg;
        if (apbWrite && paddr == `CTU_OFS_CTRL_LOW) begin
            ctrlLow_next = pwdata[7:0];
        end
        // hardware set wins over a software clear in the same cycle
        ctrlLow_next[`CTU_LO_ONE_FLAG] = ctrlLow_next[`CTU_LO_ONE_FLAG] | oneSet;
        ctrlLow_next[`CTU_LO_TWO_FLAG] = ctrlLow_next[`CTU_LO_TWO_FLAG] | twoSet;
    end

    // current source gated by exactly one flag set
    wire srcOnNow  = unitRunning & (flagOne ^ flagTwo);
    wire srcOffEvt = srcOnPrev_reg & ~srcOnNow;
    wire delayEvt  = unitRunning & delayGenEn & cmpLevel_reg & ~cmpPrev_reg;

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    always @* begin
        irqStatus_next = irqStatus_reg;
        if (apbWrite && paddr == `CTU_OFS_IRQ_CLEAR) begin
            irqStatus_next = irqStatus_reg & ~pwdata[`CTU_IRQ_WIDTH-1:0];
        end
        if (srcOffEvt) begin
            irqStatus_next[`CTU_IRQ_SRC_OFF] = 1'b1;
        end
        if (delayEvt) begin
            irqStatus_next[`CTU_IRQ_DELAY_END] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state and outputs
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            ctrlHigh_reg       <= `CTU_HI_RESET;
            ctrlLow_reg        <= `CTU_LO_RESET;
            irqStatus_reg      <= `CTU_IRQ_RESET;
            irqEnable_reg      <= `CTU_IRQ_RESET;
            srcOnPrev_reg      <= 1'b0;
            cmpPrev_reg        <= 1'b0;
            currentSourceOn    <= 1'b0;
            sourceGround       <= 1'b0;
            chargeToComparator <= 1'b0;
            adcTrigger         <= 1'b0;
            delayDone          <= 1'b0;
            irq                <= 1'b0;
        end else begin
            if (apbWrite && paddr == `CTU_OFS_CTRL_HIGH) begin
                ctrlHigh_reg <= pwdata[7:0] & `CTU_HI_IMPL_MASK;
            end
            if (apbWrite && paddr == `CTU_OFS_IRQ_ENABLE) begin
                irqEnable_reg <= pwdata[`CTU_IRQ_WIDTH-1:0];
            end
            ctrlLow_reg        <= ctrlLow_next;
            irqStatus_reg      <= irqStatus_next;
            srcOnPrev_reg      <= srcOnNow;
            cmpPrev_reg        <= cmpLevel_reg;
            currentSourceOn    <= srcOnNow;
            sourceGround       <= ctrlHigh_reg[`CTU_HI_SRC_GROUND];
            chargeToComparator <= unitRunning & delayGenEn;
            adcTrigger         <= srcOffEvt & adcTrigEn;
            delayDone          <= delayEvt;
            irq                <= |(irqStatus_next & irqEnable_reg);
        end
    end

    // ----------------------------------------------------------------
    // apb read path
    // ----------------------------------------------------------------
    always @* begin
        readData = 32'h0000_0000;
        addrHit  = 1'b1;
        if (paddr == `CTU_OFS_CTRL_HIGH) begin
            readData[7:0] = ctrlHigh_reg & `CTU_HI_IMPL_MASK;
        end else if (paddr == `CTU_OFS_CTRL_LOW) begin
            readData[7:0] = ctrlLow_reg;
        end else if (paddr == `CTU_OFS_IRQ_STATUS) begin
            readData[`CTU_IRQ_WIDTH-1:0] = irqStatus_reg;
        end else if (paddr == `CTU_OFS_IRQ_CLEAR) begin
            readData = 32'h0000_0000;
        end else if (paddr == `CTU_OFS_IRQ_ENABLE) begin
            readData[`CTU_IRQ_WIDTH-1:0] = irqEnable_reg;
        end else begin
            addrHit = 1'b0;
        end
    end

    // read data latched in the setup cycle so it stands flopped in the access cycle
    always @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetup && !pwrite) begin
            prdata <= readData;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addrHit;

endmodule // ctu_edge_ctrl

`default_nettype wire

// file: tb/ctu_edge_ctrl_monitor.sv
// assertion checker for the charge time edge control block
`timescale 1ns/100ps
`default_nettype none
`include "ctu_defines.vh"
module ctu_edge_ctrl_monitor #(
    parameter ADDR_WIDTH = 12
) (
    // clock, reset and apb
    input wire logic                  core_clk,
    input wire logic                  srst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    // device state and outputs
    input wire logic                  idleMode,
    input wire logic                  currentSourceOn,
    input wire logic                  sourceGround,
    input wire logic                  chargeToComparator,
    input wire logic                  adcTrigger,
    input wire logic                  irq
);
    logic [7:0] hiReg;
    logic [1:0] enReg;
    wire        wrAcc = psel && penable && pwrite;
    // shadow of the control-high and interrupt enable registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hiReg <= 8'h00;
            enReg <= 2'h0;
        end else if (wrAcc && paddr == `CTU_OFS_CTRL_HIGH) begin
            hiReg <= pwdata[7:0] & `CTU_HI_IMPL_MASK;
        end else if (wrAcc && paddr == `CTU_OFS_IRQ_ENABLE) begin
            enReg <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_srcOff;
        currentSourceOn ##1 !currentSourceOn;
    endsequence
    property p_unitOff;
        !hiReg[7] |=> !currentSourceOn;
    endproperty
    property p_idleStop;
        hiReg[5] && idleMode |=> !currentSourceOn;
    endproperty
    property p_delayGen;
        chargeToComparator == $past(hiReg[7] && hiReg[4] && !(hiReg[5] && idleMode));
    endproperty
    property p_ground;
        sourceGround == $past(hiReg[1]);
    endproperty
    // the trigger pulse rises on the same edge at which the source output falls
    property p_trigger;
        adcTrigger |-> ($past(hiReg[0]) && $past(currentSourceOn)
            && !currentSourceOn) ##1 !adcTrigger;
    endproperty
    property p_rsvdBit;
        psel && penable && !pwrite && paddr == `CTU_OFS_CTRL_HIGH |-> !prdata[6];
    endproperty
    property p_irqMask;
        irq |-> $past(enReg) != 2'h0;
    endproperty
    property p_irqSet;
        (s_srcOff ##0 (enReg[0] && hiReg[7] && !idleMode)) |=> irq;
    endproperty
    a_unitOff: assert property (p_unitOff) else $error("source on while disabled");
    a_idleStop: assert property (p_idleStop) else $error("source on in idle");
    a_delayGen: assert property (p_delayGen) else $error("comparator route wrong");
    a_ground: assert property (p_ground) else $error("ground output wrong");
    a_trigger: assert property (p_trigger) else $error("bad converter trigger");
    a_rsvdBit: assert property (p_rsvdBit) else $error("bit 6 reads one");
    a_irqMask: assert property (p_irqMask) else $error("irq while masked");
    a_irqSet: assert property (p_irqSet) else $error("irq missing after source off");
endmodule // ctu_edge_ctrl_monitor
bind ctu_edge_ctrl ctu_edge_ctrl_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon (.core_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .idleMode, .currentSourceOn,
    .sourceGround, .chargeToComparator, .adcTrigger, .irq);
`default_nettype wire

// file: tb/ctu_partner.sv
// model of the edge sources and delay comparator
`timescale 1ns/100ps
`default_nettype none
module ctu_partner #(
    parameter CHARGE_CYCLES = 6
) (
    // clock and requested levels: pin a, pin b, compare one, compare two
    input  wire logic       core_clk,
    input  wire logic [3:0] wantLevels,
    input  wire logic       chargeToComparator,
    // source and comparator lines
    output var  logic       edgePinA,
    output var  logic       edgePinB,
    output var  logic       cmpOneTrig,
    output var  logic       cmpTwoTrig,
    output wire logic       delayCmpOut
);
    int chargeCnt = 0;
    initial {edgePinA, edgePinB, cmpOneTrig, cmpTwoTrig} = 4'h0;
    always @(posedge core_clk) begin
        {edgePinA, edgePinB, cmpOneTrig, cmpTwoTrig} <= wantLevels;
    end
    // charging node crosses the threshold after a fixed time
    always @(posedge core_clk) begin
        if (!chargeToComparator)
            chargeCnt <= 0;
        else if (chargeCnt != CHARGE_CYCLES)
            chargeCnt <= chargeCnt + 1;
    end
    assign delayCmpOut = (chargeCnt == CHARGE_CYCLES);
endmodule // ctu_partner
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the charge time edge control block
`timescale 1ns/100ps
`default_nettype none
`include "ctu_defines.vh"
module tb_top;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  wantLevels = 4'h0;
    logic        idleMode = 1'b0;
    logic [31:0] rd;
    logic        rdErr;
    int          n_errors = 0;
    int          checks_done = 0;
    int          trigCount = 0;
    int          doneCount = 0;
    wire         pready, pslverr, edgePinA, edgePinB, cmpOneTrig, cmpTwoTrig, delayCmpOut;
    wire         currentSourceOn, sourceGround, chargeToComparator, adcTrigger, delayDone, irq;
    wire  [31:0] prdata;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        trigCount <= trigCount + (adcTrigger === 1'b1);
        doneCount <= doneCount + (delayDone === 1'b1);
    end
    ctu_edge_ctrl #(.ADDR_WIDTH(12)) uut (.core_clk, .srst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .pslverr, .prdata, .edgePinA, .edgePinB, .cmpOneTrig,
        .cmpTwoTrig, .idleMode, .delayCmpOut, .currentSourceOn, .sourceGround,
        .chargeToComparator, .adcTrigger, .delayDone, .irq);
    ctu_partner peer (.core_clk, .wantLevels, .chargeToComparator, .edgePinA, .edgePinB,
        .cmpOneTrig, .cmpTwoTrig, .delayCmpOut);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // configure with the unit off, then apply levels and read the edge flags
    task automatic sense(input logic [7:0] hi, lo, input logic [3:0] lv, input logic [1:0] f);
        wantLevels <= 4'h0;
        apb(`CTU_OFS_CTRL_HIGH, 1'b1, 32'h0);
        repeat (8) @(posedge core_clk);
        apb(`CTU_OFS_CTRL_LOW, 1'b1, {24'h0, lo});
        apb(`CTU_OFS_CTRL_HIGH, 1'b1, {24'h0, hi});
        wantLevels <= lv;
        repeat (10) @(posedge core_clk);
        apb(`CTU_OFS_CTRL_LOW, 1'b0, 32'h0);
        chk(rd[1:0], f);
    endtask
    task automatic t_regs;
        apb(`CTU_OFS_CTRL_HIGH, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(`CTU_OFS_CTRL_HIGH, 1'b1, 32'h42);
        apb(`CTU_OFS_CTRL_HIGH, 1'b0, 32'h0);
        chk(rd, 32'h02);
        chk(sourceGround, 1'b1);
        apb(12'h020, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk(rdErr, 1'b1);
    endtask
    task automatic t_sources;
        logic [1:0] s;
        logic [1:0] t;
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            t = s + 2'd1;
            sense(8'h88, {1'b1, t, 1'b1, s, 2'b00}, ~(4'h1 << s), 2'b10);
            sense(8'h88, {1'b1, t, 1'b1, s, 2'b00}, 4'h1 << s, 2'b01);
            chk(currentSourceOn, 1'b1);
            sense(8'h88, {1'b1, s, 1'b1, t, 2'b00}, 4'h1 << s, 2'b10);
        end
        sense(8'h88, 8'h00, 4'h0, 2'b11);
        chk(currentSourceOn, 1'b0);
        sense(8'h80, 8'h94, 4'h2, 2'b00);
        sense(8'h08, 8'h94, 4'h2, 2'b00);
        idleMode <= 1'b1;
        sense(8'hA8, 8'h94, 4'h2, 2'b00);
        sense(8'h88, 8'h94, 4'h2, 2'b01);
        idleMode <= 1'b0;
    endtask
    task automatic t_order;
        chk(trigCount, 0);
        sense(8'h8D, 8'h94, 4'h1, 2'b00);
        apb(`CTU_OFS_IRQ_CLEAR, 1'b1, 32'h3);
        apb(`CTU_OFS_IRQ_ENABLE, 1'b1, 32'h1);
        wantLevels <= 4'h3;
        repeat (10) @(posedge core_clk);
        apb(`CTU_OFS_CTRL_LOW, 1'b0, 32'h0);
        chk(rd[1:0], 2'b11);
        chk(trigCount, 1);
        chk(irq, 1'b1);
        apb(`CTU_OFS_IRQ_STATUS, 1'b0, 32'h0);
        chk(rd[0], 1'b1);
        apb(`CTU_OFS_IRQ_ENABLE, 1'b1, 32'h0);
        // irq falls one edge after the edge that ends the write, as apb returns: look once it has settled
        @(negedge core_clk);
        chk(irq, 1'b0);
        @(posedge core_clk);
        apb(`CTU_OFS_IRQ_CLEAR, 1'b1, 32'h1);
        apb(`CTU_OFS_IRQ_ENABLE, 1'b1, 32'h1);
        chk(irq, 1'b0);
    endtask
    task automatic t_delay;
        int m;
        m = doneCount;
        apb(`CTU_OFS_CTRL_HIGH, 1'b1, 32'h90);
        repeat (16) @(posedge core_clk);
        chk(chargeToComparator, 1'b1);
        chk(doneCount, m + 1);
        apb(`CTU_OFS_CTRL_HIGH, 1'b1, 32'h0);
        @(negedge core_clk);
        chk(chargeToComparator, 1'b0);
        @(posedge core_clk);
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_sources();
        t_order();
        t_delay();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
